// *** rtl/lbcg_top.sv ***
// low-speed peripheral bus clock gate register and its gates
`timescale 1ns/1ps
`include "lbcg_defs.svh"
module lbcg_top (
  input  wire logic                 clk_sys_i,
  input  wire logic                 rstn_i,
  input  wire lbcg_pkg::lbcg_addr_t addr_i,
  input  wire lbcg_pkg::lbcg_word_t wdata_i,
  input  wire lbcg_pkg::lbcg_be_t   be_i,
  input  wire logic                 wr_i,
  input  wire logic                 rd_i,
  output lbcg_pkg::lbcg_word_t      rdata_o,
  output lbcg_pkg::lbcg_word_t      low_speed_bus_clock_gates_o,
  output lbcg_pkg::lbcg_word_t      clk_gated_o
);
  import lbcg_pkg::*;

  lbcg_core_if core ();

  lbcg_word_t gates;
  lbcg_word_t next_gates;

  lbcg_bus_slave u_bus (
    .clk_sys_i (clk_sys_i),
    .rstn_i    (rstn_i),
    .addr_i    (addr_i),
    .wdata_i   (wdata_i),
    .be_i      (be_i),
    .wr_i      (wr_i),
    .rd_i      (rd_i),
    .rdata_o   (rdata_o),
    .core      (core.bus)
  );

  lbcg_clock_gate #(
    .N (32)
  ) u_gate (
    .clk_sys_i   (clk_sys_i),
    .rstn_i      (rstn_i),
    .clk_gated_o (clk_gated_o),
    .core        (core.gate)
  );

  // reserved positions are masked on write, so stray ones never reach a gate
  always_comb begin
    next_gates = (gates & ~core.wr_mask) | (core.wr_data & core.wr_mask);
    next_gates = next_gates & `LBCG_WRITABLE;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      gates <= `LBCG_GATES_RESET;
    end else if (core.wr_hit) begin
      gates <= next_gates;
    end
  end

  assign core.gates = gates;

  // a copy, so software state is visible without a bus read
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      low_speed_bus_clock_gates_o <= `LBCG_GATES_RESET;
    end else if (core.wr_hit) begin
      low_speed_bus_clock_gates_o <= next_gates;
    end
  end

  reset_zero_a: assert property (@(posedge clk_sys_i)
    !rstn_i |=> gates == `LBCG_GATES_RESET && core.gate_on == `LBCG_ZERO_WORD)
    else $error("gate register not zero after reset");

  lane_write_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    core.wr_hit |=> gates == (($past(gates) & ~$past(core.wr_mask))
                   | ($past(wdata_i) & $past(core.wr_mask) & `LBCG_WRITABLE)))
    else $error("byte lane write wrong");

  reserved_zero_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (gates & ~`LBCG_WRITABLE) == `LBCG_ZERO_WORD)
    else $error("reserved bit set");

  hold_value_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    !core.wr_hit |=> $stable(gates))
    else $error("gate register changed without write");

  converter_gate_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    core.gate_on[`LBCG_BIT_CONVERTER] == gates[`LBCG_BIT_CONVERTER])
    else $error("converter clock gate mismatch");

  power_gate_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    core.wr_hit && wdata_i[`LBCG_BIT_POWER] && core.wr_mask[`LBCG_BIT_POWER]
    |=> core.gate_on[`LBCG_BIT_POWER])
    else $error("power unit clock not started");

  backup_gate_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    core.wr_hit && !wdata_i[`LBCG_BIT_BACKUP] && core.wr_mask[`LBCG_BIT_BACKUP]
    |=> !core.gate_on[`LBCG_BIT_BACKUP])
    else $error("backup interface clock not stopped");

  can_gates_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    core.gate_on[`LBCG_BIT_CAN_SECOND:`LBCG_BIT_CAN_FIRST]
    == gates[`LBCG_BIT_CAN_SECOND:`LBCG_BIT_CAN_FIRST])
    else $error("CAN clock gates mismatch");

  i2c_gates_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    core.gate_on[`LBCG_BIT_I2C_SECOND:`LBCG_BIT_I2C_FIRST]
    == gates[`LBCG_BIT_I2C_SECOND:`LBCG_BIT_I2C_FIRST])
    else $error("I2C clock gates mismatch");

  async_gates_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    core.gate_on[`LBCG_BIT_ASYNC_FIFTH:`LBCG_BIT_ASYNC_FOURTH]
    == low_speed_bus_clock_gates_o[`LBCG_BIT_ASYNC_FIFTH:`LBCG_BIT_ASYNC_FOURTH])
    else $error("async port clock gates mismatch");

  sync_gates_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    core.gate_on[`LBCG_BIT_SYNC_THIRD:`LBCG_BIT_SYNC_SECOND]
    == low_speed_bus_clock_gates_o[`LBCG_BIT_SYNC_THIRD:`LBCG_BIT_SYNC_SECOND])
    else $error("sync/async port clock gates mismatch");

  spi_gates_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    core.gate_on[`LBCG_BIT_SPI_THIRD:`LBCG_BIT_SPI_SECOND]
    == gates[`LBCG_BIT_SPI_THIRD:`LBCG_BIT_SPI_SECOND])
    else $error("SPI clock gates mismatch");

  watchdog_gate_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    !gates[`LBCG_BIT_WATCHDOG] [*2] |-> !core.gate_on[`LBCG_BIT_WATCHDOG])
    else $error("watchdog clock runs while disabled");

  timer_gates_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    core.gate_on[`LBCG_BIT_TIMER_SIX:`LBCG_BIT_TIMER_ONE]
    == low_speed_bus_clock_gates_o[`LBCG_BIT_TIMER_SIX:`LBCG_BIT_TIMER_ONE])
    else $error("timer clock gates mismatch");

  byte_write_c: cover property (@(posedge clk_sys_i) disable iff (!rstn_i)
    core.wr_hit && $onehot(be_i));
  half_write_c: cover property (@(posedge clk_sys_i) disable iff (!rstn_i)
    core.wr_hit && (be_i == 4'h3 || be_i == 4'hc));
  all_on_c: cover property (@(posedge clk_sys_i) disable iff (!rstn_i)
    gates == `LBCG_WRITABLE);
  gate_off_c: cover property (@(posedge clk_sys_i) disable iff (!rstn_i)
    $fell(core.gate_on[`LBCG_BIT_CONVERTER]));

endmodule : lbcg_top

// *** include/lbcg_defs.svh ***
// constants of the low-speed bus clock gate register block
`ifndef LBCG_DEFS_SVH
`define LBCG_DEFS_SVH

`define LBCG_ADDR_W           8
`define LBCG_OFF_GATES        8'h1c
`define LBCG_GATES_RESET      32'h0000_0000
`define LBCG_WRITABLE         32'h3e7e_c83f
`define LBCG_ZERO_WORD        32'h0000_0000
`define LBCG_LANES            4
`define LBCG_LANE_W           8

`define LBCG_BIT_CONVERTER    29
`define LBCG_BIT_POWER        28
`define LBCG_BIT_BACKUP       27
`define LBCG_BIT_CAN_SECOND   26
`define LBCG_BIT_CAN_FIRST    25
`define LBCG_BIT_I2C_SECOND   22
`define LBCG_BIT_I2C_FIRST    21
`define LBCG_BIT_ASYNC_FIFTH  20
`define LBCG_BIT_ASYNC_FOURTH 19
`define LBCG_BIT_SYNC_THIRD   18
`define LBCG_BIT_SYNC_SECOND  17
`define LBCG_BIT_SPI_THIRD    15
`define LBCG_BIT_SPI_SECOND   14
`define LBCG_BIT_WATCHDOG     11
`define LBCG_BIT_TIMER_SIX    5
`define LBCG_BIT_TIMER_ONE    0

`endif

// *** include/lbcg_pkg.sv ***
// types and lane decoding shared by the clock gate block
package lbcg_pkg;
  `include "lbcg_defs.svh"

  typedef logic [31:0]                  lbcg_word_t;
  typedef logic [`LBCG_ADDR_W-1:0]      lbcg_addr_t;
  typedef logic [`LBCG_LANES-1:0]       lbcg_be_t;

  // widens byte enables into a bit mask
  function automatic lbcg_word_t lbcg_lane_mask(input lbcg_be_t be);
    lbcg_word_t m;
    m = `LBCG_ZERO_WORD;
    for (int i = 0; i < `LBCG_LANES; i++) begin
      m[i*`LBCG_LANE_W +: `LBCG_LANE_W] = {`LBCG_LANE_W{be[i]}};
    end
    return m;
  endfunction : lbcg_lane_mask
endpackage : lbcg_pkg

// *** include/lbcg_core_if.sv ***
// carrier between bus slave, gate register and clock gates
`timescale 1ns/1ps
interface lbcg_core_if;
  import lbcg_pkg::*;
  logic       wr_hit;
  lbcg_word_t wr_data;
  lbcg_word_t wr_mask;
  lbcg_word_t gates;
  lbcg_word_t gate_on;
  modport bus  (output wr_hit, output wr_data, output wr_mask, input gates);
  modport regs (input wr_hit, input wr_data, input wr_mask, output gates, input gate_on);
  modport gate (input gates, output gate_on);
endinterface : lbcg_core_if

// *** rtl/lbcg_bus_slave.sv ***
// register port decode, byte-lane masking and registered read data
`timescale 1ns/1ps
`include "lbcg_defs.svh"
module lbcg_bus_slave (
  input  wire logic            clk_sys_i,
  input  wire logic            rstn_i,
  input  wire lbcg_pkg::lbcg_addr_t addr_i,
  input  wire lbcg_pkg::lbcg_word_t wdata_i,
  input  wire lbcg_pkg::lbcg_be_t   be_i,
  input  wire logic            wr_i,
  input  wire logic            rd_i,
  output lbcg_pkg::lbcg_word_t rdata_o,
  lbcg_core_if.bus             core
);
  import lbcg_pkg::*;

  logic hit;

  always_comb begin
    if (addr_i[`LBCG_ADDR_W-1:2] == (`LBCG_ADDR_W-2)'(`LBCG_OFF_GATES >> 2)) begin
      hit = 1'b1;
    end else begin
      hit = 1'b0;
    end
  end

  assign core.wr_hit  = wr_i & hit;
  assign core.wr_data = wdata_i;
  assign core.wr_mask = lbcg_lane_mask(be_i);

  // unmapped reads and idle cycles answer zero
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      rdata_o <= `LBCG_ZERO_WORD;
    end else if (rd_i && hit) begin
      rdata_o <= core.gates & lbcg_lane_mask(be_i);
    end else begin
      rdata_o <= `LBCG_ZERO_WORD;
    end
  end

  readback_word_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (rd_i && hit && be_i == 4'hf) |=> rdata_o == $past(core.gates))
    else $error("read data differ from gate register");

endmodule : lbcg_bus_slave

// *** rtl/lbcg_clock_gate.sv ***
// glitch-free clock gates, enable retimed on the falling edge
`timescale 1ns/1ps
module lbcg_clock_gate #(
  parameter int N = 32
) (
  input  wire logic         clk_sys_i,
  input  wire logic         rstn_i,
  output logic [N-1:0]      clk_gated_o,
  lbcg_core_if.gate         core
);
  import lbcg_pkg::*;

  // enable moves only while the clock is low, so no pulse is ever cut short
  for (genvar g = 0; g < N; g++) begin : g_gate
    always_ff @(negedge clk_sys_i) begin
      if (!rstn_i) begin
        core.gate_on[g] <= 1'b0;
      end else begin
        core.gate_on[g] <= core.gates[g];
      end
    end
    assign clk_gated_o[g] = clk_sys_i & core.gate_on[g];
  end

  glitch_free_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    core.gate_on == core.gates)
    else $error("gate enable not settled before rising edge");

endmodule : lbcg_clock_gate

// *** bench/test_apb1_peripheral_clock_enables.sv ***
// self-checking bench for the low-speed bus clock gate block
`timescale 1ns/1ps
module test_apb1_peripheral_clock_enables;
  import lbcg_pkg::*;
  typedef struct packed {
    lbcg_be_t   be;
    lbcg_word_t data;
    lbcg_word_t want;
  } lbcg_row_s;
  localparam lbcg_addr_t GATE_OFF = 8'h1c;
  localparam lbcg_word_t ZERO_W   = 32'h0000_0000;
  logic       clk_sys_i = 1'b0;
  logic       rstn_i    = 1'b0;
  lbcg_addr_t addr_i    = 8'h00;
  lbcg_word_t wdata_i   = 32'h0000_0000;
  lbcg_be_t   be_i      = 4'h0;
  logic       wr_i      = 1'b0;
  logic       rd_i      = 1'b0;
  lbcg_word_t rdata_o;
  lbcg_word_t copy_o;
  lbcg_word_t clk_gated_o;
  int         n_errors    = 0;
  int         checks_done = 0;
  // each row is applied to the state the row before it left behind
  lbcg_row_s  rows [8] = '{
    '{4'hf, 32'hffff_ffff, 32'h3e7e_c83f},
    '{4'h1, 32'h0000_0000, 32'h3e7e_c800},
    '{4'h2, 32'h0000_0000, 32'h3e7e_0000},
    '{4'hc, 32'h0000_0000, 32'h0000_0000},
    '{4'h8, 32'hffff_ffff, 32'h3e00_0000},
    '{4'h4, 32'h00ff_0000, 32'h3e7e_0000},
    '{4'h3, 32'h0000_ffff, 32'h3e7e_c83f},
    '{4'hf, 32'h0000_0000, 32'h0000_0000}};
  int         gate_bits [20] = '{29, 28, 27, 26, 25, 22, 21, 20, 19, 18,
                                 17, 15, 14, 11, 5, 4, 3, 2, 1, 0};

  lbcg_top uut (
    .clk_sys_i                   (clk_sys_i),
    .rstn_i                      (rstn_i),
    .addr_i                      (addr_i),
    .wdata_i                     (wdata_i),
    .be_i                        (be_i),
    .wr_i                        (wr_i),
    .rd_i                        (rd_i),
    .rdata_o                     (rdata_o),
    .low_speed_bus_clock_gates_o (copy_o),
    .clk_gated_o                 (clk_gated_o)
  );

  always #2.5 clk_sys_i = ~clk_sys_i;

  task automatic check(input lbcg_word_t seen, input lbcg_word_t want);
    checks_done++;
    if (seen !== want) begin
      n_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask : check

  task automatic bus_write(input lbcg_addr_t a, input lbcg_word_t d, input lbcg_be_t b);
    @(posedge clk_sys_i);
    addr_i  <= a;
    wdata_i <= d;
    be_i    <= b;
    wr_i    <= 1'b1;
    @(posedge clk_sys_i);
    wr_i    <= 1'b0;
  endtask : bus_write

  task automatic bus_read(input lbcg_addr_t a, input lbcg_be_t b, output lbcg_word_t d);
    @(posedge clk_sys_i);
    addr_i <= a;
    be_i   <= b;
    rd_i   <= 1'b1;
    @(posedge clk_sys_i);
    rd_i   <= 1'b0;
    #1 d = rdata_o;
  endtask : bus_read

  // high phase must carry the enabled set, low phase nothing at all
  task automatic check_clk(input lbcg_word_t want);
    @(posedge clk_sys_i);
    #1 check(clk_gated_o, want);
    @(negedge clk_sys_i);
    #1 check(clk_gated_o, ZERO_W);
  endtask : check_clk

  task automatic summarize();
    if (n_errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize

  initial begin : main
    lbcg_word_t d;
    repeat (2) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    bus_read(GATE_OFF, 4'hf, d);
    check(d, ZERO_W);
    check(copy_o, ZERO_W);
    check_clk(ZERO_W);
    foreach (rows[i]) begin
      bus_write(GATE_OFF, rows[i].data, rows[i].be);
      bus_read(GATE_OFF, 4'hf, d);
      check(d, rows[i].want);
      check(copy_o, rows[i].want);
    end
    foreach (gate_bits[i]) begin
      bus_write(GATE_OFF, 32'h1 << gate_bits[i], 4'hf);
      check_clk(32'h1 << gate_bits[i]);
    end
    bus_write(GATE_OFF, 32'hc181_37c0, 4'hf);
    bus_read(GATE_OFF, 4'hf, d);
    check(d, ZERO_W);
    check_clk(ZERO_W);
    bus_write(GATE_OFF, 32'hffff_ffff, 4'hf);
    bus_read(GATE_OFF, 4'h2, d);
    check(d, 32'h0000_c800);
    @(posedge clk_sys_i);
    #1 check(rdata_o, ZERO_W);
    // unmapped offset must neither write nor answer
    bus_write(8'h20, ZERO_W, 4'hf);
    bus_read(8'h20, 4'hf, d);
    check(d, ZERO_W);
    check(copy_o, 32'h3e7e_c83f);
    check_clk(32'h3e7e_c83f);
    @(posedge clk_sys_i);
    rstn_i <= 1'b0;
    @(posedge clk_sys_i);
    #1 check(copy_o, ZERO_W);
    check_clk(ZERO_W);
    @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    bus_read(GATE_OFF, 4'hf, d);
    check(d, ZERO_W);
    summarize();
  end

  initial begin : watchdog
    #100000;
    n_errors++;
    summarize();
  end
endmodule : test_apb1_peripheral_clock_enables
